// File: logic/uel_pkg.sv
// Package: register map, field positions and timing for the endpoint/DMA/LPM control block
package uel_pkg;
    // Register offsets (byte addresses, word aligned)
    localparam logic [7:0] EP_TXCSR_OFS   = 8'h00;
    localparam logic [7:0] DMA_FLAGS_OFS  = 8'h04;
    localparam logic [7:0] LPM_CTRL_OFS   = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS   = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h10;
    localparam logic [7:0] EP_STAT_OFS    = 8'h14;

    // Endpoint control/status field positions
    localparam int AUTO_SET_BIT  = 31;
    localparam int ISO_BIT       = 30;
    localparam int DIR_BIT       = 29;
    localparam int DREQ_EN_BIT   = 28;
    localparam int FORCE_TG_BIT  = 27;
    localparam int DREQ_MD_BIT   = 26;
    localparam int TG_WEN_BIT    = 25;
    localparam int TG_STATE_BIT  = 24;
    localparam int TX_RDY_BIT    = 16;
    localparam int MAXP_LSB      = 0;
    localparam int MAXP_W        = 11;

    // Link power control field positions
    localparam int LPM_IE_LSB    = 24;
    localparam int LPM_IE_W      = 6;
    localparam int NAK_ONLY_BIT  = 20;
    localparam int LPM_SEL_LSB   = 18;
    localparam int RESUME_BIT    = 17;
    // Writable bits of the link power control register
    localparam logic [31:0] LPM_WR_MASK = 32'h3f1e_0000;

    // Support select encodings
    localparam logic [1:0] LPM_SEL_NONE  = 2'h2;
    localparam logic [1:0] LPM_SEL_EXT   = 2'h1;

    // Interrupt status bit positions
    localparam int IRQ_DMA_BIT   = 0;
    localparam int IRQ_LPM_BIT   = 1;
    localparam int IRQ_RES_BIT   = 2;
    localparam int IRQ_W         = 3;

    // Reset values
    localparam logic [31:0] EP_TXCSR_RST = 32'h0000_0000;
    localparam logic [31:0] LPM_CTRL_RST = 32'h0000_0000;

    // Resume signalling time and its cycle count at 125 MHz
    localparam int RESUME_US      = 50;
    localparam int CLK_MHZ        = 125;
    localparam int RESUME_CYCLES  = RESUME_US * CLK_MHZ;
    localparam int RESUME_CNT_W   = 14;
endpackage

// File: logic/uel_ctrl.sv
// Endpoint transmit options, DMA channel flags and link power control logic
module uel_ctrl #(
    parameter int DMA_CH      = 8,
    parameter int RESUME_CNT  = uel_pkg::RESUME_CYCLES
) (
    input  wire logic              mclk_i,          // Module clock
    input  wire logic              rstn_i,          // Async reset, active low
    input  wire logic [7:0]        addr_i,          // Register byte address
    input  wire logic [31:0]       wdata_i,         // Write data
    input  wire logic              wr_i,            // Write strobe
    input  wire logic              rd_i,            // Read strobe
    output logic [31:0]            rdata_o,         // Read data, cycle after strobe
    input  wire logic              host_mode_i,     // 1 host mode, 0 device mode
    input  wire logic              fifo_full_pkt_i, // Max-size packet loaded in TX FIFO
    input  wire logic              tx_sent_i,       // Packet sent, host acknowledged
    input  wire logic              dma_need_i,      // Endpoint wants DMA service
    input  wire logic [DMA_CH-1:0] dma_evt_i,       // Per-channel DMA interrupt events
    input  wire logic [5:0]        lpm_evt_i,       // LPM err,res,ack,nyet,stall,timeout
    input  wire logic              lpm_suspended_i, // Module is LPM suspended
    input  wire logic              lpm_txn_i,       // Current transaction is LPM
    output logic                   tx_pkt_ready_o,  // Transmit packet ready
    output logic                   iso_mode_o,      // Endpoint isochronous
    output logic                   dir_tx_o,        // Endpoint direction transmit
    output logic                   dma_req_o,       // DMA request
    output logic                   dma_req_mode_o,  // DMA request mode 1
    output logic                   fifo_flush_o,    // Clear packet from FIFO
    output logic                   toggle_o,        // Current transmit data toggle
    output logic                   nak_o,           // Answer with NAK
    output logic                   lpm_supported_o, // LPM transactions supported
    output logic                   ext_supported_o, // Extended transactions supported
    output logic                   resume_o,        // Drive resume signalling
    output logic [5:0]             lpm_irq_o,       // Enabled LPM interrupt pulses
    output logic                   irq_o            // Level interrupt
);
    logic [31:0]                 csr_ff;
    logic                        toggle_ff;
    logic                        tx_rdy_ff;
    logic [DMA_CH-1:0]           dflag_ff;
    logic [31:0]                 lpm_ff;
    logic                        nak_req_ff;
    logic                        nak_act_ff;
    logic [uel_pkg::RESUME_CNT_W-1:0] res_cnt_ff;
    logic [uel_pkg::IRQ_W-1:0]   ist_ff;
    logic [uel_pkg::IRQ_W-1:0]   imask_ff;
    logic [31:0]                 rdata_ff;
    logic                        dma_req_ff;
    logic                        flush_ff;
    logic [5:0]                  lpm_irq_ff;
    logic                        irq_ff;
    logic                        nak_ff;
    logic                        lpm_sup_ff;
    logic                        ext_sup_ff;
    logic                        iso_ff;
    logic [uel_pkg::IRQ_W-1:0]   nxt_ist;
    logic [DMA_CH-1:0]           nxt_dflag;
    logic [5:0]                  lpm_hit;

    logic wr_csr;
    logic wr_lpm;
    logic rd_dma;
    logic force_tg;
    logic res_done;
    assign wr_csr   = wr_i && (addr_i == uel_pkg::EP_TXCSR_OFS);
    assign wr_lpm   = wr_i && (addr_i == uel_pkg::LPM_CTRL_OFS);
    assign rd_dma   = rd_i && (addr_i == uel_pkg::DMA_FLAGS_OFS);
    assign force_tg = csr_ff[uel_pkg::FORCE_TG_BIT];
    assign res_done = lpm_ff[uel_pkg::RESUME_BIT] && (res_cnt_ff == '0);
    assign lpm_hit  = lpm_evt_i & lpm_ff[uel_pkg::LPM_IE_LSB +: uel_pkg::LPM_IE_W];

    // Endpoint control register; software may clear request mode only after
    // request enable is already low, so the two are stored independently
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            csr_ff <= uel_pkg::EP_TXCSR_RST;
        end else if (wr_csr) begin
            csr_ff <= wdata_i;
        end
    end

    // Transmit packet ready: software sets, auto-set on full packet, cleared on send
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_rdy_ff <= 1'b0;
        end else if (csr_ff[uel_pkg::AUTO_SET_BIT] && fifo_full_pkt_i) begin
            tx_rdy_ff <= 1'b1;
        end else if (wr_csr && wdata_i[uel_pkg::TX_RDY_BIT]) begin
            tx_rdy_ff <= 1'b1;
        end else if (tx_sent_i || force_tg) begin
            tx_rdy_ff <= 1'b0;
        end
    end

    // Data toggle: flips on ack or forced switch, host write gated by enable
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            toggle_ff <= 1'b0;
        end else if (host_mode_i && wr_csr && wdata_i[uel_pkg::TG_WEN_BIT]) begin
            toggle_ff <= wdata_i[uel_pkg::TG_STATE_BIT];
        end else if (tx_sent_i || (force_tg && tx_rdy_ff)) begin
            toggle_ff <= ~toggle_ff;
        end
    end

    // Forced flush of the pending packet, whether or not an ACK came
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flush_ff <= 1'b0;
        end else begin
            flush_ff <= force_tg && tx_rdy_ff;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dma_req_ff <= 1'b0;
        end else begin
            dma_req_ff <= csr_ff[uel_pkg::DREQ_EN_BIT] && dma_need_i;
        end
    end

    // Isochronous select is forced off in host mode, where the bit has no effect
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            iso_ff <= 1'b0;
        end else if (wr_csr) begin
            iso_ff <= wdata_i[uel_pkg::ISO_BIT] && !host_mode_i;
        end else begin
            iso_ff <= csr_ff[uel_pkg::ISO_BIT] && !host_mode_i;
        end
    end

    // DMA channel flags, set wins over read-clear
    generate
        for (genvar i = 0; i < DMA_CH; i++) begin : g_dflag
            assign nxt_dflag[i] = dma_evt_i[i] ? 1'b1 : (rd_dma ? 1'b0 : dflag_ff[i]);
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dflag_ff <= '0;
        end else begin
            dflag_ff <= nxt_dflag;
        end
    end

    // Link power control register; resume bit self-clears
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lpm_ff <= uel_pkg::LPM_CTRL_RST;
        end else if (wr_lpm) begin
            lpm_ff <= wdata_i & uel_pkg::LPM_WR_MASK;
            if (lpm_ff[uel_pkg::RESUME_BIT]) begin
                lpm_ff[uel_pkg::RESUME_BIT] <= 1'b1;
            end
        end else if (res_done) begin
            lpm_ff[uel_pkg::RESUME_BIT] <= 1'b0;
        end
    end

    // Resume counter runs 50 us from the write of one
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            res_cnt_ff <= '0;
        end else if (wr_lpm && wdata_i[uel_pkg::RESUME_BIT] && !lpm_ff[uel_pkg::RESUME_BIT]) begin
            res_cnt_ff <= uel_pkg::RESUME_CNT_W'(RESUME_CNT - 1);
        end else if (res_cnt_ff != '0) begin
            res_cnt_ff <= res_cnt_ff - 1'b1;
        end
    end

    // NAK-only: a written one waits for LPM suspend before acting
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nak_req_ff <= 1'b0;
            nak_act_ff <= 1'b0;
        end else begin
            nak_req_ff <= lpm_ff[uel_pkg::NAK_ONLY_BIT];
            if (!lpm_ff[uel_pkg::NAK_ONLY_BIT]) begin
                nak_act_ff <= 1'b0;
            end else if (lpm_suspended_i) begin
                nak_act_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nak_ff <= 1'b0;
        end else begin
            nak_ff <= nak_act_ff && !lpm_txn_i;
        end
    end

    // Support decode, device mode only
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lpm_sup_ff <= 1'b0;
            ext_sup_ff <= 1'b0;
        end else begin
            lpm_sup_ff <= !host_mode_i &&
                          (lpm_ff[uel_pkg::LPM_SEL_LSB +: 2] != uel_pkg::LPM_SEL_NONE) &&
                          (lpm_ff[uel_pkg::LPM_SEL_LSB +: 2] != uel_pkg::LPM_SEL_EXT);
            ext_sup_ff <= !host_mode_i &&
                          (lpm_ff[uel_pkg::LPM_SEL_LSB +: 2] != uel_pkg::LPM_SEL_NONE);
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lpm_irq_ff <= '0;
        end else begin
            lpm_irq_ff <= lpm_hit;
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_comb begin
        nxt_ist = ist_ff;
        if (wr_i && (addr_i == uel_pkg::IRQ_STAT_OFS)) begin
            nxt_ist = ist_ff & ~wdata_i[uel_pkg::IRQ_W-1:0];
        end
        if (|dma_evt_i) begin
            nxt_ist[uel_pkg::IRQ_DMA_BIT] = 1'b1;
        end
        if (|lpm_hit) begin
            nxt_ist[uel_pkg::IRQ_LPM_BIT] = 1'b1;
        end
        if (res_done) begin
            nxt_ist[uel_pkg::IRQ_RES_BIT] = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ist_ff   <= '0;
            imask_ff <= '0;
            irq_ff   <= 1'b0;
        end else begin
            ist_ff <= nxt_ist;
            if (wr_i && (addr_i == uel_pkg::IRQ_MASK_OFS)) begin
                imask_ff <= wdata_i[uel_pkg::IRQ_W-1:0];
            end
            irq_ff <= |(nxt_ist & imask_ff);
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads return zero
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= '0;
        end else if (rd_i) begin
            if (addr_i == uel_pkg::EP_TXCSR_OFS) begin
                rdata_ff <= {csr_ff[31], csr_ff[30] && !host_mode_i, csr_ff[29:25],
                             toggle_ff, 7'h00, tx_rdy_ff, 5'h00,
                             csr_ff[uel_pkg::MAXP_LSB +: uel_pkg::MAXP_W]};
            end else if (addr_i == uel_pkg::DMA_FLAGS_OFS) begin
                rdata_ff <= 32'(dflag_ff);
            end else if (addr_i == uel_pkg::LPM_CTRL_OFS) begin
                rdata_ff <= lpm_ff;
            end else if (addr_i == uel_pkg::IRQ_STAT_OFS) begin
                rdata_ff <= 32'(ist_ff);
            end else if (addr_i == uel_pkg::IRQ_MASK_OFS) begin
                rdata_ff <= 32'(imask_ff);
            end else if (addr_i == uel_pkg::EP_STAT_OFS) begin
                rdata_ff <= {29'h0, nak_act_ff, nak_req_ff, flush_ff};
            end else begin
                rdata_ff <= '0;
            end
        end else begin
            rdata_ff <= '0;
        end
    end

    assign rdata_o         = rdata_ff;
    assign tx_pkt_ready_o  = tx_rdy_ff;
    assign iso_mode_o      = iso_ff;
    assign dir_tx_o        = csr_ff[uel_pkg::DIR_BIT];
    assign dma_req_o       = dma_req_ff;
    assign dma_req_mode_o  = csr_ff[uel_pkg::DREQ_MD_BIT];
    assign fifo_flush_o    = flush_ff;
    assign toggle_o        = toggle_ff;
    assign nak_o           = nak_ff;
    assign lpm_supported_o = lpm_sup_ff;
    assign ext_supported_o = ext_sup_ff;
    assign resume_o        = lpm_ff[uel_pkg::RESUME_BIT];
    assign lpm_irq_o       = lpm_irq_ff;
    assign irq_o           = irq_ff;
endmodule

// File: tb/uel_asserts.sv
// Checker for the endpoint, DMA flag and link power control block
module uel_asserts #(
    parameter int RESUME_CNT = 20
) (
    input wire logic        mclk_i,          // Clock
    input wire logic        rstn_i,          // Reset
    input wire logic [7:0]  addr_i,          // Address
    input wire logic [31:0] wdata_i,         // Write data
    input wire logic        wr_i,            // Write strobe
    input wire logic        host_mode_i,     // Host mode
    input wire logic        fifo_full_pkt_i, // Packet loaded
    input wire logic        dma_need_i,      // DMA wanted
    input wire logic [5:0]  lpm_evt_i,       // LPM events
    input wire logic        lpm_suspended_i, // Suspended
    input wire logic        tx_pkt_ready_o,  // Packet ready
    input wire logic        dma_req_o,       // DMA request
    input wire logic        fifo_flush_o,    // Flush
    input wire logic        toggle_o,        // Toggle
    input wire logic        nak_o,           // NAK
    input wire logic        lpm_supported_o, // LPM support
    input wire logic        ext_supported_o, // Ext support
    input wire logic        resume_o,        // Resume
    input wire logic [5:0]  lpm_irq_o        // LPM irqs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic nak_bit_ff;
    logic susp_seen_ff;
    logic susp_or_seen;
    logic lpm_wr;
    assign lpm_wr       = wr_i && (addr_i == 8'h08);
    assign susp_or_seen = susp_seen_ff || lpm_suspended_i;
    // Suspend seen since the NAK-only bit was last written from 0 to 1
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nak_bit_ff   <= 1'b0;
            susp_seen_ff <= 1'b0;
        end else begin
            if (lpm_wr) begin
                nak_bit_ff <= wdata_i[20];
            end
            if (lpm_wr && (!wdata_i[20] || !nak_bit_ff)) begin
                susp_seen_ff <= 1'b0;
            end else if (lpm_suspended_i) begin
                susp_seen_ff <= 1'b1;
            end
        end
    end
    int unsigned res_cnt_ff;
    // Length of the current resume burst
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            res_cnt_ff <= 0;
        end else begin
            res_cnt_ff <= resume_o ? res_cnt_ff + 1 : 0;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    chk_pkt_cause: assert property ($rose(tx_pkt_ready_o) |-> $past(fifo_full_pkt_i)
        || ($past(wr_i) && $past(addr_i) == 8'h00 && $past(wdata_i[16])))
        else $error("packet ready rose without a cause");
    chk_dreq_gate: assert property (dma_req_o |-> $past(dma_need_i))
        else $error("DMA request without need");
    chk_flush_toggle: assert property (fifo_flush_o |-> ##[0:1] $changed(toggle_o))
        else $error("flush without toggle switch");
    chk_lpm_gate: assert property (lpm_irq_o != 6'h0 |->
        (lpm_irq_o & ~$past(lpm_evt_i)) == 6'h0)
        else $error("LPM interrupt without event");
    chk_nak_suspend: assert property (nak_o |-> $past(susp_or_seen, 2))
        else $error("NAK active before suspend");
    chk_host_support: assert property (host_mode_i && $past(host_mode_i) |->
        !lpm_supported_o && !ext_supported_o)
        else $error("support shown in host mode");
    chk_resume_len: assert property ($fell(resume_o) |-> res_cnt_ff == RESUME_CNT)
        else $error("resume length wrong");
    chk_resume_clear: assert property (resume_o |-> res_cnt_ff < RESUME_CNT)
        else $error("resume not cleared in time");
    cover property ($fell(resume_o));
    cover property ($rose(nak_o));
    cover property (fifo_flush_o);
endmodule
bind uel_ctrl uel_asserts #(.RESUME_CNT(RESUME_CNT)) uel_asserts_inst (.*);

// File: tb/uel_host_model.sv
// Behavioural model of the USB host side and packet path
module uel_host_model (
    input  wire logic       mclk_i,          // Clock
    output logic            fifo_full_pkt_o, // Packet loaded
    output logic            tx_sent_o,       // Packet acked
    output logic            dma_need_o,      // DMA wanted
    output logic [7:0]      dma_evt_o,       // Channel events
    output logic [5:0]      lpm_evt_o,       // LPM events
    output logic            lpm_suspended_o, // Suspended
    output logic            lpm_txn_o        // LPM transaction
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {fifo_full_pkt_o, tx_sent_o, dma_need_o, dma_evt_o} = '0;
        {lpm_evt_o, lpm_suspended_o, lpm_txn_o} = '0;
    end
    task automatic pulse(input logic f, input logic s, input logic [7:0] d,
                         input logic [5:0] l);
        @(posedge mclk_i);
        fifo_full_pkt_o <= f;
        tx_sent_o       <= s;
        dma_evt_o       <= d;
        lpm_evt_o       <= l;
        @(posedge mclk_i);
        {fifo_full_pkt_o, tx_sent_o, dma_evt_o, lpm_evt_o} <= '0;
    endtask
    task automatic level(input logic n, input logic s, input logic t);
        @(posedge mclk_i);
        dma_need_o      <= n;
        lpm_suspended_o <= s;
        lpm_txn_o       <= t;
    endtask
endmodule

// File: tb/uel_ctrl_tb.sv
// Testbench for the endpoint, DMA flag and link power control block
module uel_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RCNT = 20;
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        host_mode_i = 1'b0;
    logic [31:0] rdata_o, rd_v;
    logic [7:0]  dma_evt_i;
    logic [5:0]  lpm_evt_i, lpm_irq_o;
    logic        fifo_full_pkt_i, tx_sent_i, dma_need_i, lpm_suspended_i, lpm_txn_i;
    logic        tx_pkt_ready_o, iso_mode_o, dir_tx_o, dma_req_o, dma_req_mode_o;
    logic        fifo_flush_o, toggle_o, nak_o, lpm_supported_o, ext_supported_o;
    logic        resume_o, irq_o, t;
    logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;
    always #4 mclk_i = ~mclk_i;
    uel_ctrl #(.RESUME_CNT(RCNT)) uel_ctrl_inst (.*);
    uel_host_model uel_host_model_inst (.mclk_i(mclk_i), .fifo_full_pkt_o(fifo_full_pkt_i),
        .tx_sent_o(tx_sent_i), .dma_need_o(dma_need_i), .dma_evt_o(dma_evt_i),
        .lpm_evt_o(lpm_evt_i), .lpm_suspended_o(lpm_suspended_i), .lpm_txn_o(lpm_txn_i));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        rd_v = rdata_o;
    endtask
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        foreach (ofs[i]) begin
            rd(ofs[i]);
            chk("reset", 32'h0, rd_v);
        end
        // Endpoint options in device mode, then the DMA request gate
        wr(8'h00, 32'h7400_0040);
        uel_host_model_inst.level(1'b1, 1'b0, 1'b0);
        wt(2);
        chk("dreq", 32'h1, {31'h0, dma_req_o});
        chk("opts", 32'h7, {29'h0, iso_mode_o, dir_tx_o, dma_req_mode_o});
        rd(8'h00);
        chk("ep", 32'h7400_0040, rd_v);
        wr(8'h00, 32'h6400_0040);
        wt(2);
        chk("dreq", 32'h0, {31'h0, dma_req_o});
        wr(8'h00, 32'h6000_0040);
        wt(1);
        chk("dmode", 32'h0, {31'h0, dma_req_mode_o});
        @(posedge mclk_i) host_mode_i <= 1'b1;
        rd(8'h00);
        chk("ep_host", 32'h2000_0040, rd_v);
        chk("iso_host", 32'h0, {31'h0, iso_mode_o});
        // Toggle writes in host mode
        wr(8'h00, 32'h2100_0040);
        wt(1);
        chk("tgl", 32'h0, {31'h0, toggle_o});
        wr(8'h00, 32'h2300_0040);
        rd(8'h00);
        chk("tgl", 32'h1, {31'h0, toggle_o});
        chk("tgl_rd", 32'h1, {31'h0, rd_v[24]});
        // Packet ready by hand and by auto-set, then forced toggle
        uel_host_model_inst.pulse(1'b1, 1'b0, 8'h00, 6'h00);
        wt(1);
        chk("rdy", 32'h0, {31'h0, tx_pkt_ready_o});
        wr(8'h00, 32'h2101_0040);
        wt(1);
        chk("rdy", 32'h1, {31'h0, tx_pkt_ready_o});
        uel_host_model_inst.pulse(1'b0, 1'b1, 8'h00, 6'h00);
        wr(8'h00, 32'ha100_0040);
        uel_host_model_inst.pulse(1'b1, 1'b0, 8'h00, 6'h00);
        wt(1);
        chk("rdy", 32'h1, {31'h0, tx_pkt_ready_o});
        t = toggle_o;
        wr(8'h00, 32'ha900_0040);
        wt(1);
        chk("flush", 32'h1, {31'h0, fifo_flush_o});
        wt(1);
        chk("force", {30'h0, ~t, 1'b0}, {30'h0, toggle_o, tx_pkt_ready_o});
        wr(8'h00, 32'h2100_0040);
        // Channel flags, read-clear, and an event in the read cycle
        uel_host_model_inst.pulse(1'b0, 1'b0, 8'ha5, 6'h00);
        rd(8'h04);
        chk("dflag", 32'ha5, rd_v);
        rd(8'h04);
        chk("dflag", 32'h0, rd_v);
        uel_host_model_inst.pulse(1'b0, 1'b0, 8'h0f, 6'h00);
        fork
            rd(8'h04);
            uel_host_model_inst.pulse(1'b0, 1'b0, 8'hf0, 6'h00);
        join
        chk("dflag", 32'h0f, rd_v);
        rd(8'h04);
        chk("dflag", 32'hf0, rd_v);
        // Interrupt: masked, unmasked, cleared
        chk("irq", 32'h0, {31'h0, irq_o});
        wr(8'h10, 32'h1);
        wt(2);
        chk("irq", 32'h1, {31'h0, irq_o});
        wr(8'h0c, 32'h7);
        wt(2);
        chk("irq", 32'h0, {31'h0, irq_o});
        for (int i = 0; i < 6; i++) begin
            wr(8'h08, 32'h1 << (24 + i));
            uel_host_model_inst.pulse(1'b0, 1'b0, 8'h00, 6'h3f);
            #1;
            chk("lirq", 32'h1 << i, {26'h0, lpm_irq_o});
        end
        @(posedge mclk_i) host_mode_i <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            wr(8'h08, 32'(s) << 18);
            wt(1);
            chk("sup", {30'h0, s != 2 && s != 1, s != 2},
                {30'h0, lpm_supported_o, ext_supported_o});
        end
        // NAK-only waits for suspend
        wr(8'h08, 32'h1 << 20);
        wt(3);
        chk("nak", 32'h0, {31'h0, nak_o});
        uel_host_model_inst.level(1'b0, 1'b1, 1'b0);
        wt(3);
        chk("nak", 32'h1, {31'h0, nak_o});
        rd(8'h14);
        chk("ep_stat", 32'h6, rd_v);
        uel_host_model_inst.level(1'b0, 1'b1, 1'b1);
        wt(2);
        chk("nak_lpm", 32'h0, {31'h0, nak_o});
        uel_host_model_inst.level(1'b0, 1'b1, 1'b0);
        wt(2);
        chk("nak", 32'h1, {31'h0, nak_o});
        wr(8'h08, 32'h0);
        wt(3);
        chk("nak", 32'h0, {31'h0, nak_o});
        uel_host_model_inst.level(1'b0, 1'b0, 1'b0);
        // Remote wake-up
        wr(8'h08, 32'h1 << 17);
        wt(2);
        chk("res", 32'h1, {31'h0, resume_o});
        wt(RCNT - 3);
        chk("res_len", 32'h1, {31'h0, resume_o});
        wt(1);
        chk("res_end", 32'h0, {31'h0, resume_o});
        rd(8'h08);
        chk("res", 32'h0, {30'h0, resume_o, rd_v[17]});
        rd(8'h0c);
        chk("res_st", 32'h1, {31'h0, rd_v[2]});
        print_verdict();
    end
endmodule
